// *** design/tpx_counter.sv ***
// Saturating up-counter with synchronous clear, used for every timer of the transceiver
`timescale 1ns/1ps
module tpx_counter #(
   parameter int W = 6
) (
   input  wire logic         mclk,
   input  wire logic         reset_n,
   input  wire logic         clr,
   output logic [W-1:0]      cnt
);
   typedef struct packed {
      logic [W-1:0] cnt;
   } tpx_cnt_s;

   tpx_cnt_s st;
   tpx_cnt_s next_st;

   // Clear wins over counting; sticking at all ones keeps long gaps from wrapping back
   always_comb begin
      next_st = st;
      if (clr) begin
         next_st.cnt = '0;
      end else if (st.cnt != {W{1'b1}}) begin
         next_st.cnt = st.cnt + W'(1);
      end
   end

   // State register
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign cnt = st.cnt;

   // A clear always lands on zero next cycle
   clear_zero_a: assert property (@(posedge mclk) disable iff (!reset_n) clr |=> (cnt == '0))
      else $error("counter did not clear");
endmodule

// *** design/tpx_transceiver.sv ***
// Package of timing constants and the digital transceiver core with its checks
package tpx_pkg;
   // ****************************************************************
   // Clock and bit time
   // ****************************************************************
   localparam int CLK_NS       = 5;
   localparam int BIT_NS       = 100;
   localparam int BIT_CYC      = BIT_NS / CLK_NS;
   localparam int OSC_MHZ      = 10;
   localparam int CLKH_CYC     = (1000 / OSC_MHZ) / 2 / CLK_NS;
   localparam int CW           = 6;

   // ****************************************************************
   // Transmit timing
   // ****************************************************************
   localparam int TXDH_NS      = 75;
   localparam int TXDH_CYC     = TXDH_NS / CLK_NS;
   localparam int EOP_NS       = 250;
   localparam int EOP_CYC      = (EOP_NS + CLK_NS - 1) / CLK_NS;
   localparam int LKPW_MIN_NS  = 80;
   localparam int LKPW_MAX_NS  = 120;
   localparam int LKPW_CYC     = (LKPW_MIN_NS + LKPW_MAX_NS) / 2 / CLK_NS;
   localparam int LINK_PER_DEF = 3_200_000;
   localparam int LW           = 22;

   // ****************************************************************
   // Receive timing
   // ****************************************************************
   localparam int BEAT_MIN_NS  = 80;
   localparam int BEAT_MAX_NS  = 192;
   localparam int BEAT_MIN_CYC = (BEAT_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int BEAT_MAX_CYC = BEAT_MAX_NS / CLK_NS;
   localparam int SQ_BITS      = 5;
   localparam int SQ_MAX_CYC   = SQ_BITS * BIT_CYC;
   localparam int SQ_EDGES     = 4;
   localparam int RXDE_MIN_NS  = 155;
   localparam int RXDE_MAX_NS  = 250;
   localparam int RXDE_MIN_CYC = (RXDE_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int RXDE_MAX_CYC = RXDE_MAX_NS / CLK_NS;
   localparam int RXDE_CYC     = 40;
   localparam int ECHO_NS      = 50;
   localparam int ECHO_CYC     = ECHO_NS / CLK_NS;
   localparam int LTRA_NS      = 30;
   localparam int LTRA_CYC     = LTRA_NS / CLK_NS;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [1:0] {
      TX_IDLE = 2'b00,
      TX_DATA = 2'b01,
      TX_HOLD = 2'b10,
      TX_LINK = 2'b11
   } tpx_tx_e;

   typedef struct packed {
      logic       p;
      logic       n;
      logic       drive;
   } tpx_pair_s;

   typedef struct packed {
      tpx_tx_e    tx_st;
      tpx_pair_s  pair;
      logic [3:0] clk_div;
      logic       clk_out;
      logic       rx_q;
      logic [2:0] edge_cnt;
      logic       sq_open;
      logic       beat;
      logic       rx_en;
      logic       rx_da;
      logic       rx_db;
   } tpx_state_s;
endpackage

`timescale 1ns/1ps
module tpx_transceiver #(
   parameter int LINK_PERIOD_CYC = tpx_pkg::LINK_PER_DEF
) (
   input  wire logic   mclk,
   input  wire logic   reset_n,
   input  wire logic   tx_en,
   input  wire logic   tx_data_a,
   input  wire logic   tx_data_b,
   input  wire logic   loop_n,
   input  wire logic   rx_line,
   output logic        tp_tx_p,
   output logic        tp_tx_n,
   output logic        tp_drive,
   output logic        rx_en,
   output logic        rx_data_a,
   output logic        rx_data_b,
   output logic        link_beat,
   output logic        clk_out
);
   import tpx_pkg::*;

   tpx_state_s     st;
   tpx_state_s     next_st;
   logic [CW-1:0]  hold_cnt;
   logic [CW-1:0]  lkpw_cnt;
   logic [CW-1:0]  gap_cnt;
   logic [CW-1:0]  hi_cnt;
   logic [LW-1:0]  link_cnt;
   logic           txd;
   logic           rx_edge;

   // ****************************************************************
   // Timers
   // ****************************************************************
   // The two inputs are never used together; the spare one is tied high, so AND merges them
   assign txd     = tx_data_a & tx_data_b;
   assign rx_edge = rx_line ^ st.rx_q;

   tpx_counter #(.W(CW)) u_hold (.mclk(mclk), .reset_n(reset_n), .clr(st.tx_st != TX_HOLD), .cnt(hold_cnt));
   tpx_counter #(.W(CW)) u_lkpw (.mclk(mclk), .reset_n(reset_n), .clr(st.tx_st != TX_LINK), .cnt(lkpw_cnt));
   tpx_counter #(.W(CW)) u_gap  (.mclk(mclk), .reset_n(reset_n), .clr(rx_edge),             .cnt(gap_cnt));
   tpx_counter #(.W(CW)) u_hi   (.mclk(mclk), .reset_n(reset_n), .clr(!st.rx_q),            .cnt(hi_cnt));
   tpx_counter #(.W(LW)) u_link (.mclk(mclk), .reset_n(reset_n), .clr(st.tx_st != TX_IDLE), .cnt(link_cnt));

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      next_st = st;
      // Oscillator copy: toggles every half period of the 10 MHz clock
      if (st.clk_div == 4'(CLKH_CYC - 1)) begin
         next_st.clk_div = 4'h0;
         next_st.clk_out = ~st.clk_out;
      end else begin
         next_st.clk_div = st.clk_div + 4'h1;
      end

      // Transmit sequencer; loopback keeps packets off the line
      case (st.tx_st)
         TX_IDLE: begin
            if (tx_en && loop_n) begin
               next_st.tx_st = TX_DATA;
            end else if (link_cnt >= LW'(LINK_PERIOD_CYC - 1)) begin
               next_st.tx_st = TX_LINK;
            end
         end
         TX_DATA: begin
            if (!tx_en || !loop_n) begin
               next_st.tx_st = TX_HOLD;
            end
         end
         TX_HOLD: begin
            if (tx_en && loop_n) begin
               next_st.tx_st = TX_DATA;
            end else if (hold_cnt >= CW'(EOP_CYC - 1)) begin
               next_st.tx_st = TX_IDLE;
            end
         end
         TX_LINK: begin
            if (lkpw_cnt >= CW'(LKPW_CYC - 1)) begin
               next_st.tx_st = TX_IDLE;
            end
         end
         default: begin
            next_st.tx_st = TX_IDLE;
         end
      endcase

      // Pair levels follow the new state so the outputs change with it
      case (next_st.tx_st)
         TX_DATA: next_st.pair = '{p: txd, n: ~txd, drive: 1'b1};
         TX_HOLD: next_st.pair = '{p: 1'b1, n: 1'b0, drive: 1'b1};
         TX_LINK: next_st.pair = '{p: 1'b1, n: 1'b0, drive: 1'b1};
         default: next_st.pair = '{p: 1'b0, n: 1'b0, drive: 1'b0};
      endcase

      // Squelch: a single link pulse has two edges, real data passes four quickly
      next_st.rx_q = rx_line;
      if (rx_edge) begin
         if (st.edge_cnt != 3'(SQ_EDGES)) begin
            next_st.edge_cnt = st.edge_cnt + 3'h1;
         end
         if (st.edge_cnt >= 3'(SQ_EDGES - 1)) begin
            next_st.sq_open = 1'b1;
         end
      end else if (gap_cnt >= CW'(RXDE_CYC - 1)) begin
         next_st.edge_cnt = 3'h0;
         next_st.sq_open  = 1'b0;
      end

      // Link beat: width of a lone high pulse judged at its falling edge
      // The high counter reads zero on the first high sample, so here it holds the width minus one
      next_st.beat = st.rx_q && !rx_line && !st.sq_open &&
                     (hi_cnt >= CW'(BEAT_MIN_CYC - 1)) && (hi_cnt <= CW'(BEAT_MAX_CYC - 1));

      // Receive side: loopback and local echo take transmit data, else the line
      if (!loop_n) begin
         next_st.rx_en = tx_en;
         next_st.rx_da = txd;
      end else if (st.sq_open) begin
         next_st.rx_en = 1'b1;
         next_st.rx_da = rx_line;
      end else begin
         next_st.rx_en = tx_en;
         next_st.rx_da = txd;
      end
      if (!next_st.rx_en) begin
         next_st.rx_da = 1'b1;
      end
      next_st.rx_db = next_st.rx_da;
   end

   // ****************************************************************
   // State register and outputs
   // ****************************************************************
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         st          <= '0;
         st.rx_da    <= 1'b1;
         st.rx_db    <= 1'b1;
         st.rx_q     <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   // Every output is a flop of the state
   assign tp_tx_p   = st.pair.p;
   assign tp_tx_n   = st.pair.n;
   assign tp_drive  = st.pair.drive;
   assign rx_en     = st.rx_en;
   assign rx_data_a = st.rx_da;
   assign rx_data_b = st.rx_db;
   assign link_beat = st.beat;
   assign clk_out   = st.clk_out;

   // ****************************************************************
   // Checks
   // ****************************************************************
   // Twenty cycles high, split into short repetitions that unroll cheaply, then released
   sequence link_high_s;
      (tp_drive && tp_tx_p && !tp_tx_n) [*8] ##1 (tp_drive && tp_tx_p && !tp_tx_n) [*8] ##1
      (tp_drive && tp_tx_p && !tp_tx_n) [*4];
   endsequence

   sequence link_end_s;
      ##1 !tp_drive;
   endsequence

   data_needs_en_a: assert property (@(posedge mclk) disable iff (!reset_n)
      (st.tx_st == TX_DATA) |-> $past(tx_en) && $past(loop_n))
      else $error("packet data sent without transmit enable");
   tx_forward_a: assert property (@(posedge mclk) disable iff (!reset_n)
      (st.tx_st == TX_DATA && tx_en && loop_n) |=> (tp_tx_p == $past(txd)) && (tp_tx_n != tp_tx_p))
      else $error("transmit data not forwarded");
   idle_high_a: assert property (@(posedge mclk) disable iff (!reset_n)
      (st.tx_st == TX_DATA && !tx_en) |-> ##[1:TXDH_CYC] (tp_tx_p && !tp_tx_n))
      else $error("pair not idle high after enable fell");
   eop_hold_a: assert property (@(posedge mclk) disable iff (!reset_n)
      (st.tx_st == TX_HOLD && !tx_en && hold_cnt < CW'(EOP_CYC - 1)) |=> tp_drive)
      else $error("end of packet hold cut short");
   link_width_a: assert property (@(posedge mclk) disable iff (!reset_n)
      $rose(st.tx_st == TX_LINK) |-> link_high_s ##0 link_end_s)
      else $error("link pulse width wrong");
   beat_window_a: assert property (@(posedge mclk) disable iff (!reset_n)
      link_beat |-> ($past(hi_cnt) >= CW'(BEAT_MIN_CYC - 1)) && ($past(hi_cnt) <= CW'(BEAT_MAX_CYC - 1)))
      else $error("link beat outside width window");
   squelch_open_a: assert property (@(posedge mclk) disable iff (!reset_n)
      (rx_edge && st.edge_cnt == 3'(SQ_EDGES - 1) && loop_n) |-> ##[1:2] rx_en)
      else $error("squelch did not release");
   rx_close_a: assert property (@(posedge mclk) disable iff (!reset_n)
      $fell(st.sq_open) |-> ($past(gap_cnt) == CW'(RXDE_CYC - 1)) && !$past(rx_edge))
      else $error("receive shut down at wrong time");
   echo_en_a: assert property (@(posedge mclk) disable iff (!reset_n)
      ($rose(tx_en) && loop_n) |-> ##[1:ECHO_CYC] rx_en)
      else $error("receive enable did not echo transmit");
   echo_data_a: assert property (@(posedge mclk) disable iff (!reset_n)
      (tx_en && loop_n && !st.sq_open) |=> (rx_data_a == $past(txd)))
      else $error("transmit data not echoed");
   loop_follow_a: assert property (@(posedge mclk) disable iff (!reset_n)
      (!loop_n && $changed(tx_en)) |-> ##[1:ECHO_CYC] (rx_en == tx_en))
      else $error("loopback enable not followed");
   loop_data_a: assert property (@(posedge mclk) disable iff (!reset_n)
      (!loop_n && tx_en) |=> (rx_data_a == $past(txd)) && (rx_data_b == rx_data_a))
      else $error("loopback data wrong");
   loop_exit_a: assert property (@(posedge mclk) disable iff (!reset_n)
      ($rose(loop_n) && !st.sq_open && $stable(tx_en)) |-> ##[1:LTRA_CYC] (rx_en == tx_en))
      else $error("receive enable not back on transmit enable");
   clock_half_a: assert property (@(posedge mclk) disable iff (!reset_n)
      $rose(clk_out) |-> ##CLKH_CYC $fell(clk_out))
      else $error("clock output half period wrong");
   line_data_a: assert property (@(posedge mclk) disable iff (!reset_n)
      (st.sq_open && loop_n) |=> (rx_data_a == $past(rx_line)))
      else $error("line data not presented");
   rx_high_a: assert property (@(posedge mclk) disable iff (!reset_n)
      !rx_en |-> (rx_data_a && rx_data_b))
      else $error("receive data not high while disabled");
   loop_line_a: assert property (@(posedge mclk) disable iff (!reset_n)
      !loop_n |=> (st.tx_st != TX_DATA))
      else $error("packet data on line in loopback");
endmodule

// *** tb/tpx_hub_port.sv ***
// Hub port model that sends fixed-pattern packets on transmit enable and data
`timescale 1ns/1ps
module tpx_hub_port
   import tpx_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       reset_n,
   input  wire logic       go,
   input  wire logic [7:0] len,
   output logic            tx_en,
   output logic            tx_data
);
   logic [7:0] bits;
   logic [4:0] cyc;

   // Data toggles once a bit time, so a packet of even length ends low
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         tx_en   <= 1'b0;
         tx_data <= 1'b1;
         bits    <= 8'h00;
         cyc     <= 5'h00;
      end else if (!tx_en) begin
         if (go) begin
            tx_en   <= 1'b1;
            tx_data <= 1'b1;
            bits    <= len - 8'h01;
            cyc     <= 5'h00;
         end
      end else if (cyc == 5'(BIT_CYC - 1)) begin
         cyc <= 5'h00;
         if (bits == 8'h00) begin
            tx_en   <= 1'b0;
            tx_data <= 1'b1;   // Idle data sits high, as an unused input would
         end else begin
            bits    <= bits - 8'h01;
            tx_data <= ~tx_data;
         end
      end else begin
         cyc <= cyc + 5'h01;
      end
   end
endmodule

// *** tb/test_tpx_transceiver.sv ***
// Self-checking testbench of the transceiver core driven by a hub port model
`timescale 1ns/1ps
module test_tpx_transceiver;
   import tpx_pkg::*;
   localparam int LP = 200;   // Short link pulse spacing keeps the run brief
   logic       mclk, reset_n, go, sel_b, loop_n, rx_line, tx_en, pdata;
   logic       tp_tx_p, tp_tx_n, tp_drive, rx_en, rx_data_a, rx_data_b, link_beat, clk_out;
   logic [2:0] h_en, h_txd;
   int         n_fail, n_compared, cyc;

   tpx_transceiver #(.LINK_PERIOD_CYC(LP)) u_dut (
      .mclk(mclk), .reset_n(reset_n), .tx_en(tx_en), .tx_data_a(sel_b ? 1'b1 : pdata),
      .tx_data_b(sel_b ? pdata : 1'b1), .loop_n(loop_n), .rx_line(rx_line), .tp_tx_p(tp_tx_p),
      .tp_tx_n(tp_tx_n), .tp_drive(tp_drive), .rx_en(rx_en), .rx_data_a(rx_data_a),
      .rx_data_b(rx_data_b), .link_beat(link_beat), .clk_out(clk_out));
   tpx_hub_port u_port (.mclk(mclk), .reset_n(reset_n), .go(go), .len(8'h08), .tx_en(tx_en), .tx_data(pdata));

   always #2.5 mclk = ~mclk;

   // History of transmit inputs; echo is judged only once they have settled
   always @(posedge mclk) begin
      h_en  <= {h_en[1:0], tx_en};
      h_txd <= {h_txd[1:0], pdata};
   end

   // Hang guard, well beyond the few thousand cycles the tests need
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail = n_fail + 1;
         wrap_up();
      end
   end

   // ************************************************************
   // Compare and report
   // ************************************************************
   task automatic wrap_up();
      if (n_fail == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic exp, input logic got);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %b seen %b", nm, exp, got);
      end
   endtask

   task automatic chk_rng(input string nm, input int lo, input int hi, input int got);
      n_compared++;
      if (got < lo || got > hi) begin
         n_fail++;
         $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, got);
      end
   endtask

   // One cycle of packet checks: 0 normal, 1 loopback, 2 pair not judged
   task automatic watch(input int lp);
      @(negedge mclk);
      if (h_en == 3'b111 && (h_txd == 3'b000 || h_txd == 3'b111)) begin
         if (lp == 0) begin
            chk("tp_drive", 1'b1, tp_drive);
            chk("tp_tx_p", h_txd[0], tp_tx_p);
            chk("tp_tx_n", ~h_txd[0], tp_tx_n);
         end
         chk("rx_en", 1'b1, rx_en);
         chk("rx_data_a", h_txd[0], rx_data_a);
         chk("rx_data_b", h_txd[0], rx_data_b);
      end
      if (lp == 1) chk("tp_tx_n", 1'b0, tp_tx_n);
      if (rx_en === 1'b0) begin
         chk("rx_data_a", 1'b1, rx_data_a);
         chk("rx_data_b", 1'b1, rx_data_b);
      end
   endtask

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_reset();
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      chk("tp_drive", 1'b0, tp_drive);
      chk("rx_en", 1'b0, rx_en);
      chk("rx_data_a", 1'b1, rx_data_a);
      @(posedge mclk);
      reset_n <= 1'b1;
   endtask

   task automatic t_clk();
      int   n;
      logic v;
      @(negedge mclk);
      v = clk_out;
      for (n = 0; n < 30 && clk_out === v; n++) @(negedge mclk);
      v = clk_out;
      for (n = 0; n < 30 && clk_out === v; n++) @(negedge mclk);
      chk_rng("clk_out half period", CLKH_CYC, CLKH_CYC, n);
   endtask

   // Mode 0 normal, 1 loopback throughout, 2 loopback left in mid-packet
   task automatic pkt(input logic b, input int mode);
      int c, t_idle, t_off, t_rx;
      @(posedge mclk);
      sel_b  <= b;
      loop_n <= (mode == 0);
      go     <= 1'b1;
      @(posedge mclk);
      go <= 1'b0;
      c = 0;
      do begin
         if (mode == 2 && c == 60) loop_n <= 1'b1;
         watch(mode == 2 ? (c < 60 ? 1 : 2) : mode);
         if (mode == 2 && c == 60 + LTRA_CYC - 1) chk("rx_en", 1'b1, rx_en);
         @(posedge mclk);
         c++;
      end while (c < 400 && !(c > 2 && tx_en === 1'b0));
      t_idle = -1;
      t_off  = -1;
      t_rx   = -1;
      for (c = 0; c < 80; c++) begin
         @(negedge mclk);
         if (t_idle < 0 && tp_tx_p === 1'b1 && tp_tx_n === 1'b0) t_idle = c;
         if (t_off < 0 && tp_drive === 1'b0) t_off = c;
         if (t_rx < 0 && rx_en === 1'b0) t_rx = c;
         if (mode == 1) chk("tp_tx_n", 1'b0, tp_tx_n);
      end
      if (mode == 0) begin
         chk_rng("idle high delay", 0, TXDH_CYC, t_idle);
         chk_rng("end hold", EOP_CYC, EOP_CYC + 10, t_off);
      end
      if (mode == 1) chk_rng("loop rx_en drop", 0, ECHO_CYC, t_rx);
   endtask

   task automatic t_link();
      int n, w;
      for (n = 0; n < 400 && tp_drive !== 1'b1; n++) @(negedge mclk);
      for (w = 0; w < 60 && tp_drive === 1'b1 && tp_tx_p === 1'b1 && tp_tx_n === 1'b0; w++) @(negedge mclk);
      chk_rng("link pulse width", LKPW_MIN_NS / CLK_NS, LKPW_MAX_NS / CLK_NS, w);
   endtask

   // Twelve edges half a bit time apart, then silence until shutdown
   task automatic t_rx();
      int c, t_open;
      t_open = -1;
      for (c = 0; c < 120; c++) begin
         @(posedge mclk);
         if (c % 10 == 0) rx_line <= ~rx_line;
         @(negedge mclk);
         if (t_open < 0 && rx_en === 1'b1) t_open = c;
         if (rx_en === 1'b1 && c % 10 >= 3) chk("rx_data_a", rx_line, rx_data_a);
         if (rx_en === 1'b0) chk("rx_data_a", 1'b1, rx_data_a);
      end
      chk_rng("squelch open", 0, SQ_MAX_CYC, t_open);
      for (c = 9; c < 100 && rx_en !== 1'b0; c++) @(negedge mclk);
      chk_rng("rx shutdown", RXDE_MIN_CYC, RXDE_MAX_CYC, c);
   endtask

   // Single pulses one cycle outside and just inside each end of the accepted width band
   task automatic t_beat();
      int   w[4] = '{15, 16, 38, 39};
      logic e[4] = '{1'b0, 1'b1, 1'b1, 1'b0};
      logic seen;
      for (int i = 0; i < 4; i++) begin
         @(posedge mclk);
         rx_line <= 1'b1;
         repeat (w[i]) @(posedge mclk);
         rx_line <= 1'b0;
         seen = 1'b0;
         repeat (6) begin
            @(negedge mclk);
            seen = seen | link_beat;
         end
         chk("link_beat", e[i], seen);
         chk("rx_en", 1'b0, rx_en);
         repeat (50) @(posedge mclk);
      end
   endtask

   initial begin
      mclk       = 1'b0;
      reset_n    = 1'b0;
      go         = 1'b0;
      sel_b      = 1'b0;
      loop_n     = 1'b1;
      rx_line    = 1'b0;
      h_en       = 3'b000;
      h_txd      = 3'b000;
      n_fail     = 0;
      n_compared = 0;
      cyc        = 0;
      t_reset();
      t_clk();
      pkt(1'b0, 0);
      pkt(1'b1, 0);
      pkt(1'b0, 1);
      pkt(1'b0, 2);
      t_link();
      t_rx();
      t_beat();
      wrap_up();
   end
endmodule
